// *** verilog/qrsp_pkg.sv ***
`default_nettype none
package qrsp_pkg;
  // lane and burst geometry
  localparam int QRSP_LANE_W         = 9;
  localparam int QRSP_BURST_LEN      = 2;
  localparam int QRSP_WORD_W_NARROW  = 18;
  localparam int QRSP_WORD_W_WIDE    = 36;
  localparam int QRSP_ADDR_W_NARROW  = 18;
  localparam int QRSP_ADDR_W_WIDE    = 17;
  // buffering and pin sampling
  localparam int QRSP_FIFO_DEPTH     = 16;
  localparam int QRSP_SYNC_STAGES    = 2;
  localparam int QRSP_LINK_CLK_PINS  = 4;
  // port selects and byte selects are active low
  localparam logic QRSP_SEL_ACTIVE   = 1'h0;
  localparam logic QRSP_OE_ON        = 1'h1;
  localparam logic QRSP_OE_OFF       = 1'h0;

  typedef enum logic [1:0] {
    QRSP_RD_IDLE  = 2'b00,
    QRSP_RD_WORD0 = 2'b01,
    QRSP_RD_WORD1 = 2'b10
  } qrsp_rd_state_type;
endpackage
`default_nettype wire

// *** verilog/qrsp_fifo_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface qrsp_fifo_if #(
  parameter int WIDTH = 8
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport fifo_side (
    input  push_valid,
    input  push_data,
    output push_ready,
    output pop_valid,
    output pop_data,
    input  pop_ready
  );

  modport user_side (
    output push_valid,
    output push_data,
    input  push_ready,
    input  pop_valid,
    input  pop_data,
    output pop_ready
  );
endinterface
`default_nettype wire

// *** verilog/qrsp_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module qrsp_fifo import qrsp_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = QRSP_FIFO_DEPTH
) (
  input  wire logic        i_sys_clk, // system clock
  input  wire logic        i_rst,     // async reset, active high
  qrsp_fifo_if.fifo_side   io         // push and pop handshakes
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wr_ptr_q;
  logic [PW:0]      rd_ptr_q;
  wire              full;
  wire              empty;
  wire              push_fire;
  wire              pop_fire;

  assign empty         = (wr_ptr_q == rd_ptr_q);
  assign full          = (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]) && (wr_ptr_q[PW] != rd_ptr_q[PW]);
  assign io.push_ready = !full;
  assign io.pop_valid  = !empty;
  assign io.pop_data   = mem_q[rd_ptr_q[PW-1:0]];
  assign push_fire     = io.push_valid && !full;
  assign pop_fire      = io.pop_ready && !empty;

  always_ff @(posedge i_sys_clk) begin
    if (push_fire) begin
      mem_q[wr_ptr_q[PW-1:0]] <= io.push_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push_fire) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop_fire) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/qrsp_port_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - write data captured on both input clock rising edges; 18 or 36 bits.
// - write select sampled low on positive input clock starts a write.
// - write select sampled high deselects; write data ignored that cycle.
// - byte selects sampled with the data word they qualify, on both edges.
// - each byte select bit governs one 9-bit lane, bit 0 the lowest.
// - lane with inactive byte select is discarded; stored lane stays unchanged.
// - shared address: read address on positive edge, write address on negative edge.
// - each address holds two words; 18 address bits narrow, 17 wide.
// - address for a deselected port is ignored.
// - read words launched on both output clock edges, input clocks in single mode.
// - output bus is high impedance while the read port is idle.
// - read select sampled low on positive input clock starts a read.
// - deselect finishes pending read, then tri-states after next positive output edge.
// - every read returns exactly two sequential words of the location.
// - every access begins on a positive input clock rising edge.
// - free running echo clock pair follows output clock, or input clock.
module qrsp_port_logic import qrsp_pkg::*; #(
  parameter int WORD_W     = QRSP_WORD_W_NARROW,
  parameter int ADDR_W     = QRSP_ADDR_W_NARROW,
  parameter int FIFO_DEPTH = QRSP_FIFO_DEPTH
) (
  input  wire logic                          i_sys_clk,             // 125 MHz system clock
  input  wire logic                          i_rst,                 // async reset, active high
  input  wire logic                          i_k_clk,               // positive input clock pin
  input  wire logic                          i_k_clk_n,             // negative input clock pin
  input  wire logic                          i_c_clk,               // positive output clock pin
  input  wire logic                          i_c_clk_n,             // negative output clock pin
  input  wire logic                          i_single_clk_mode,     // high: launch on input clocks
  input  wire logic [ADDR_W-1:0]             i_addr,                // shared address bus
  input  wire logic [WORD_W-1:0]             i_data,                // write data bus
  input  wire logic                          i_write_port_select_n, // write request, low
  input  wire logic                          i_read_port_select_n,  // read request, low
  input  wire logic [WORD_W/QRSP_LANE_W-1:0] i_byte_write_select_n, // lane enables, low
  output logic      [WORD_W-1:0]             o_q,                   // read data out
  output logic                               o_q_oe,                // read data drive enable
  output logic                               o_echo_clock,          // echo clock, positive
  output logic                               o_echo_clock_n,        // echo clock, negative
  output logic                               o_write_overrun        // burst dropped, pulse
);
  localparam int LANES   = WORD_W / QRSP_LANE_W;
  localparam int SYNC_W  = QRSP_LINK_CLK_PINS + 3 + LANES + ADDR_W + WORD_W;
  localparam int ENTRY_W = ADDR_W + QRSP_BURST_LEN * (LANES + WORD_W);

  generate
    if (!((WORD_W == QRSP_WORD_W_NARROW && ADDR_W <= QRSP_ADDR_W_NARROW) ||
          (WORD_W == QRSP_WORD_W_WIDE && ADDR_W <= QRSP_ADDR_W_WIDE)) || ADDR_W < 1) begin : g_bad
      $error("word width must be 18 or 36 with at most 18 or 17 address bits");
    end
  endgenerate

  // every pin crosses two flops before use; data skews with the clocks it rides on
  logic [SYNC_W-1:0]             sync1_q;
  logic [SYNC_W-1:0]             sync2_q;
  logic [QRSP_LINK_CLK_PINS-1:0] clk_prev_q;
  logic [QRSP_SYNC_STAGES:0]     warm_q;
  wire                           kp_s;
  wire                           kn_s;
  wire                           cp_s;
  wire                           cn_s;
  wire                           single_s;
  wire                           wps_n_s;
  wire                           rps_n_s;
  wire  [LANES-1:0]              bws_n_s;
  wire  [ADDR_W-1:0]             addr_s;
  wire  [WORD_W-1:0]             data_s;

  assign {kp_s, kn_s, cp_s, cn_s, single_s, wps_n_s, rps_n_s, bws_n_s, addr_s, data_s} = sync2_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      clk_prev_q <= '0;
      warm_q     <= '0;
    end else begin
      warm_q     <= {warm_q[QRSP_SYNC_STAGES-1:0], 1'h1};
      sync1_q    <= {i_k_clk, i_k_clk_n, i_c_clk, i_c_clk_n, i_single_clk_mode,
                     i_write_port_select_n, i_read_port_select_n, i_byte_write_select_n,
                     i_addr, i_data};
      sync2_q    <= sync1_q;
      clk_prev_q <= {kp_s, kn_s, cp_s, cn_s};
    end
  end

  wire kp_rise;
  wire kn_rise;
  wire oc_p_rise;
  wire oc_n_rise;
  wire edge_ok;
  // a pin resting high at reset release would look like a rise; wait until the chain is full
  assign edge_ok   = warm_q[QRSP_SYNC_STAGES];
  assign kp_rise   = edge_ok && kp_s && !clk_prev_q[3];
  assign kn_rise   = edge_ok && kn_s && !clk_prev_q[2];
  assign oc_p_rise = single_s ? kp_rise : (edge_ok && cp_s && !clk_prev_q[1]);
  assign oc_n_rise = single_s ? kn_rise : (edge_ok && cn_s && !clk_prev_q[0]);

  // echo clocks run always, independent of any access
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_echo_clock   <= 1'h0;
      o_echo_clock_n <= 1'h0;
    end else begin
      o_echo_clock   <= single_s ? kp_s : cp_s;
      o_echo_clock_n <= single_s ? kn_s : cn_s;
    end
  end

  // ---------------- write port ----------------
  qrsp_fifo_if #(.WIDTH(ENTRY_W)) wr_fifo ();

  logic                  wr_armed_q;
  logic [WORD_W-1:0]     wr_word0_q;
  logic [LANES-1:0]      wr_bws0_q;
  logic                  push_valid_q;
  logic [ENTRY_W-1:0]    push_data_q;
  wire                   wr_take;
  wire                   wr_done;
  wire                   push_load;

  assign wr_take   = kp_rise && (wps_n_s == QRSP_SEL_ACTIVE);
  assign wr_done   = wr_armed_q && kn_rise;
  assign push_load = wr_done && (!push_valid_q || wr_fifo.push_ready);
  assign wr_fifo.push_valid = push_valid_q;
  assign wr_fifo.push_data  = push_data_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_armed_q      <= 1'h0;
      wr_word0_q      <= '0;
      wr_bws0_q       <= '1;
      push_valid_q    <= 1'h0;
      push_data_q     <= '0;
      o_write_overrun <= 1'h0;
    end else begin
      if (kp_rise) begin
        wr_armed_q <= wr_take;
      end else if (kn_rise) begin
        wr_armed_q <= 1'h0;
      end
      if (wr_take) begin
        wr_word0_q <= data_s;
        wr_bws0_q  <= bws_n_s;
      end
      if (push_load) begin
        push_valid_q <= 1'h1;
        // write address and second word come on the negative edge
        push_data_q  <= {addr_s, bws_n_s, data_s, wr_bws0_q, wr_word0_q};
      end else if (wr_fifo.push_ready) begin
        push_valid_q <= 1'h0;
      end
      o_write_overrun <= wr_done && !push_load;
    end
  end

  qrsp_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .io        (wr_fifo.fifo_side)
  );

  // ---------------- storage ----------------
  logic [1:0]                                rd_stage_q;
  logic [ADDR_W-1:0]                         rd_addr_q;
  wire  [ADDR_W-1:0]                         dr_addr;
  wire  [QRSP_BURST_LEN-1:0][LANES-1:0]      dr_bws_n;
  wire  [QRSP_BURST_LEN-1:0][WORD_W-1:0]     dr_data;
  wire  [QRSP_BURST_LEN-1:0][WORD_W-1:0]     rd_word;
  wire                                       drain_fire;

  assign {dr_addr, dr_bws_n[1], dr_data[1], dr_bws_n[0], dr_data[0]} = wr_fifo.pop_data;
  // the drain yields for one cycle while a read samples the array, so a read never
  // sees a line half updated; this stall is what lets the fifo fill
  assign wr_fifo.pop_ready = !rd_stage_q[0];
  assign drain_fire        = wr_fifo.pop_valid && wr_fifo.pop_ready;

  genvar gw;
  genvar gl;
  generate
    for (gw = 0; gw < QRSP_BURST_LEN; gw++) begin : g_word
      for (gl = 0; gl < LANES; gl++) begin : g_lane
        logic [QRSP_LANE_W-1:0] lane_mem_q [2**ADDR_W];
        logic [QRSP_LANE_W-1:0] rd_lane_q;
        always_ff @(posedge i_sys_clk) begin
          if (drain_fire && dr_bws_n[gw][gl] == QRSP_SEL_ACTIVE) begin
            lane_mem_q[dr_addr] <= dr_data[gw][gl*QRSP_LANE_W +: QRSP_LANE_W];
          end
          rd_lane_q <= lane_mem_q[rd_addr_q];
        end
        assign rd_word[gw][gl*QRSP_LANE_W +: QRSP_LANE_W] = rd_lane_q;
      end
    end
  endgenerate

  // ---------------- read port ----------------
  wire rd_take;
  assign rd_take = kp_rise && (rps_n_s == QRSP_SEL_ACTIVE);

  logic                       rd_pend_q;
  logic [WORD_W-1:0]          pend_word0_q;
  logic [WORD_W-1:0]          pend_word1_q;
  logic [WORD_W-1:0]          hold_word1_q;
  qrsp_rd_state_type          st_q;
  qrsp_rd_state_type          st_d;
  logic                       launch;
  logic                       go_word1;
  logic                       go_idle;

  always_comb begin
    st_d     = st_q;
    launch   = 1'b0;
    go_word1 = 1'b0;
    go_idle  = 1'b0;
    case (st_q)
      QRSP_RD_IDLE: begin
        if (oc_p_rise && rd_pend_q) begin
          launch = 1'b1;
          st_d   = QRSP_RD_WORD0;
        end
      end
      QRSP_RD_WORD0: begin
        if (oc_n_rise) begin
          go_word1 = 1'b1;
          st_d     = QRSP_RD_WORD1;
        end
      end
      QRSP_RD_WORD1: begin
        if (oc_p_rise && rd_pend_q) begin
          launch = 1'b1;
          st_d   = QRSP_RD_WORD0;
        end else if (oc_p_rise) begin
          go_idle = 1'b1;
          st_d    = QRSP_RD_IDLE;
        end
      end
      default: begin
        go_idle = 1'b1;
        st_d    = QRSP_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_stage_q   <= 2'h0;
      rd_addr_q    <= '0;
      rd_pend_q    <= 1'h0;
      pend_word0_q <= '0;
      pend_word1_q <= '0;
      hold_word1_q <= '0;
      st_q         <= QRSP_RD_IDLE;
      o_q          <= '0;
      o_q_oe       <= QRSP_OE_OFF;
    end else begin
      rd_stage_q <= {rd_stage_q[0], rd_take};
      if (rd_take) begin
        rd_addr_q <= addr_s;
      end
      if (rd_stage_q[1]) begin
        rd_pend_q    <= 1'h1;
        pend_word0_q <= rd_word[0];
        pend_word1_q <= rd_word[1];
      end else if (launch) begin
        rd_pend_q <= 1'h0;
      end
      st_q <= st_d;
      if (launch) begin
        o_q          <= pend_word0_q;
        hold_word1_q <= pend_word1_q;
        o_q_oe       <= QRSP_OE_ON;
      end else if (go_word1) begin
        o_q <= hold_word1_q;
      end else if (go_idle) begin
        o_q_oe <= QRSP_OE_OFF;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_burst_start;
    st_q == QRSP_RD_IDLE && oc_p_rise && rd_pend_q;
  endsequence
  sequence s_second_word;
    st_q == QRSP_RD_WORD0 && oc_n_rise;
  endsequence

  write_take_arms_a: assert property (wr_take |=> wr_armed_q)
    else $error("write request not armed");
  write_desel_idle_a: assert property (kp_rise && wps_n_s |=> !wr_armed_q && !wr_done)
    else $error("deselected write port armed");
  write_burst_push_a: assert property (
    wr_done && !push_valid_q |=> push_valid_q &&
      push_data_q[ENTRY_W-1 -: ADDR_W] == $past(addr_s))
    else $error("write burst address not pushed");
  read_take_pend_a: assert property (rd_take |-> ##2 rd_stage_q[1] ##1 rd_pend_q)
    else $error("read request not fetched");
  read_desel_quiet_a: assert property (
    kp_rise && rps_n_s && !rd_stage_q[0] && !rd_stage_q[1] && !rd_pend_q |=> !rd_pend_q)
    else $error("deselected read port fetched");
  burst_first_word_a: assert property (s_burst_start |=> o_q_oe && o_q == $past(pend_word0_q))
    else $error("first read word wrong");
  burst_second_word_a: assert property (s_second_word |=> o_q == $past(hold_word1_q) &&
    o_q_oe && st_q == QRSP_RD_WORD1)
    else $error("second read word wrong");
  burst_end_hiz_a: assert property (
    st_q == QRSP_RD_WORD1 && oc_p_rise && !rd_pend_q |=> !o_q_oe ##1 !o_q_oe)
    else $error("output not released after burst");
  idle_hiz_a: assert property (st_q == QRSP_RD_IDLE && !launch |=> !o_q_oe)
    else $error("output driven while idle");
  rw_parallel_a: assert property (wr_take && rd_take |=> wr_armed_q && rd_stage_q[0])
    else $error("concurrent read and write interfered");
endmodule
`default_nettype wire

// *** bench/qrsp_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module qrsp_ctrl_model #(
  parameter int W  = 18,
  parameter int AW = 6
) (
  output logic           o_k_clk,               // positive input clock
  output logic           o_k_clk_n,             // negative input clock
  output logic           o_c_clk,               // positive output clock
  output logic           o_c_clk_n,             // negative output clock
  output logic           o_single_clk_mode,     // launch reads on input clocks
  output logic [AW-1:0]  o_addr,                // shared address
  output logic [W-1:0]   o_data,                // write data
  output logic           o_write_port_select_n, // write request, low
  output logic           o_read_port_select_n,  // read request, low
  output logic [W/9-1:0] o_byte_write_select_n, // lane enables, low
  output logic           o_out_clk,             // output clock in use
  output logic           o_out_clk_n            // its complement
);
  // eight steps make one 125 ns link period
  localparam realtime STEP = 15.625;
  event probe;

  assign o_out_clk   = o_single_clk_mode ? o_k_clk : o_c_clk;
  assign o_out_clk_n = o_single_clk_mode ? o_k_clk_n : o_c_clk_n;

  initial begin
    o_k_clk               = 1'h0;
    o_k_clk_n             = 1'h1;
    o_c_clk               = 1'h0;
    o_c_clk_n             = 1'h1;
    o_single_clk_mode     = 1'h0;
    o_addr                = '0;
    o_data                = '0;
    o_write_port_select_n = 1'h1;
    o_read_port_select_n  = 1'h1;
    o_byte_write_select_n = '1;
  end

  // one link period; unused lines show the inverse of their last value
  task automatic cyc(input logic sm, input logic rd, input logic [AW-1:0] ra,
                     input logic wr, input logic [AW-1:0] wa, input logic [W-1:0] w0,
                     input logic [W-1:0] w1, input logic [W/9-1:0] b0,
                     input logic [W/9-1:0] b1);
    o_single_clk_mode     = sm;
    -> probe;
    o_read_port_select_n  = ~rd;
    o_write_port_select_n = ~wr;
    o_addr                = rd ? ra : ~o_addr;
    o_data                = wr ? w0 : ~o_data;
    o_byte_write_select_n = wr ? b0 : ~o_byte_write_select_n;
    #(STEP);
    // in single clock mode the output pair stands still
    if (!sm) begin
      o_c_clk   = 1'h1;
      o_c_clk_n = 1'h0;
    end
    #(STEP);
    o_k_clk   = 1'h1;
    o_k_clk_n = 1'h0;
    #(2*STEP);
    -> probe;
    o_read_port_select_n  = 1'h1;
    o_write_port_select_n = 1'h1;
    o_addr                = wr ? wa : ~o_addr;
    o_data                = wr ? w1 : ~o_data;
    o_byte_write_select_n = wr ? b1 : ~o_byte_write_select_n;
    #(STEP);
    if (!sm) begin
      o_c_clk   = 1'h0;
      o_c_clk_n = 1'h1;
    end
    #(STEP);
    o_k_clk   = 1'h0;
    o_k_clk_n = 1'h1;
    #(2*STEP);
  endtask
endmodule
`default_nettype wire

// *** bench/qrsp_port_logic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module qrsp_port_logic_tb import qrsp_pkg::*;;
  localparam int W  = QRSP_WORD_W_NARROW;
  localparam int AW = 6; // small array keeps the run short
  localparam int BW = W / QRSP_LANE_W;
  logic               i_sys_clk;
  logic               i_rst;
  logic               sm;
  wire logic          k_clk, k_clk_n, c_clk, c_clk_n, single, wps_n, rps_n, oclk, oclk_n;
  wire logic [AW-1:0] addr;
  wire logic [W-1:0]  data;
  wire logic [BW-1:0] bws_n;
  logic      [W-1:0]  q;
  logic               q_oe, echo, echo_n, overrun;
  logic      [W-1:0]  mem [2**AW][2];
  logic      [W-1:0]  exp_q [$];
  integer             seed = 72231;
  int                 num_errors = 0;
  int                 n_compared = 0;
  int                 n, k;

  qrsp_ctrl_model #(.W(W), .AW(AW)) M (
    .o_k_clk(k_clk), .o_k_clk_n(k_clk_n), .o_c_clk(c_clk), .o_c_clk_n(c_clk_n),
    .o_single_clk_mode(single), .o_addr(addr), .o_data(data),
    .o_write_port_select_n(wps_n), .o_read_port_select_n(rps_n),
    .o_byte_write_select_n(bws_n), .o_out_clk(oclk), .o_out_clk_n(oclk_n));

  qrsp_port_logic #(.WORD_W(W), .ADDR_W(AW), .FIFO_DEPTH(QRSP_FIFO_DEPTH)) DUT (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_k_clk(k_clk), .i_k_clk_n(k_clk_n),
    .i_c_clk(c_clk), .i_c_clk_n(c_clk_n), .i_single_clk_mode(single), .i_addr(addr),
    .i_data(data), .i_write_port_select_n(wps_n), .i_read_port_select_n(rps_n),
    .i_byte_write_select_n(bws_n), .o_q(q), .o_q_oe(q_oe), .o_echo_clock(echo),
    .o_echo_clock_n(echo_n), .o_write_overrun(overrun));

  initial begin
    i_sys_clk = 1'h0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] expv);
    n_compared++;
    if (got !== expv) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, expv);
    end
  endtask

  task automatic close_out();
    chk(exp_q.size(), 36'h0);
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // note expected read words, model the array, then run one link period
  task automatic op(input logic rd, input int ra, input logic wr, input int wa,
                    input logic [BW-1:0] b0, input logic [BW-1:0] b1);
    logic [W-1:0]  w [2];
    logic [BW-1:0] b [2];
    w[0] = W'($random(seed));
    w[1] = W'($random(seed));
    b[0] = b0;
    b[1] = b1;
    if (rd) begin
      k++;
      exp_q.push_back(mem[ra][0]);
      exp_q.push_back(mem[ra][1]);
    end
    if (wr)
      for (int i = 0; i < 2; i++)
        for (int l = 0; l < BW; l++)
          if (b[i][l] == QRSP_SEL_ACTIVE)
            mem[wa][i][l*QRSP_LANE_W +: QRSP_LANE_W] = w[i][l*QRSP_LANE_W +: QRSP_LANE_W];
    M.cyc(sm, rd, AW'(ra), wr, AW'(wa), w[0], w[1], b0, b1);
  endtask

  task automatic idle();
    op(1'h0, 0, 1'h0, 0, 2'h0, 2'h0);
  endtask

  // each output edge shows the word launched by the edge before it
  always @(posedge oclk or posedge oclk_n) begin
    if (q_oe === 1'h1) begin
      if (exp_q.size() == 0) chk(q, 36'hfffffffff);
      else begin
        chk(q, exp_q.pop_front());
        n++;
      end
    end
  end

  always @(M.probe) begin
    chk(echo, single ? k_clk : c_clk);
    chk(echo_n, single ? k_clk_n : c_clk_n);
  end

  // the link never outruns the drain, so no burst may be dropped
  always @(negedge i_sys_clk) if (i_rst === 1'h0) chk(overrun, 36'h0);

  initial begin
    #40000;
    num_errors++;
    $display("ERROR %0t got %h exp %h", $time, 0, 1);
    close_out();
  end

  initial begin
    i_rst = 1'h1;
    sm = 1'h0;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'h0;
    repeat (4) @(negedge i_sys_clk);
    for (int a = 0; a < 8; a++) op(a >= 2, a - 2, 1'h1, a, 2'h0, 2'h0);
    for (int a = 0; a < 8; a++) op(1'h0, 0, 1'h1, a, a[1:0], ~a[1:0]);
    repeat (2) idle();
    for (int a = 0; a < 8; a++) op(1'h1, a, 1'h0, 0, 2'h0, 2'h0);
    repeat (2) idle();
    sm = 1'h1;
    for (int a = 0; a < 4; a++) op(1'h1, a, 1'h1, 8 + a, 2'h0, 2'h0);
    repeat (2) idle();
    sm = 1'h0;
    for (int a = 8; a < 12; a++) op(1'h1, a, 1'h0, 0, 2'h0, 2'h0);
    repeat (2) idle();
    // back-to-back bursts through the write buffer to line 12, then reads of it; the latest lanes must win
    for (int a = 0; a < 4; a++) op(1'h0, 0, 1'h1, 12, a[1:0], 2'h0);
    for (int a = 0; a < 2; a++) op(1'h1, 12, 1'h1, 13 - a, 2'h0, 2'h3);
    repeat (2) idle();
    chk(n, 2 * k);
    chk(q_oe, 1'h0);
    close_out();
  end
endmodule
`default_nettype wire
